// ---- src/atc_params.svh ----
// atc_params.svh: offsets, field positions, reset values and counts
// of the ATA timing override block; definitions only.
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

`define ATC_ADDR_W        12
`define ATC_OFF_UDMA      12'h000
`define ATC_OFF_MISC      12'h004
`define ATC_OFF_TFSTB     12'h008
`define ATC_OFF_TFRCV     12'h00C
`define ATC_OFF_PIOSTB    12'h010
`define ATC_OFF_PIORCV    12'h014
`define ATC_OFF_STATUS    12'h018

`define ATC_UDMA_MASK     32'h0000_0003
`define ATC_MISC_MASK     32'h0077_0001
`define ATC_TIME_MASK     32'h0000_7F7F
`define ATC_REG_RESET     32'h0000_0000

`define ATC_OVR_BIT       0
`define ATC_HOLD1_MSB     22
`define ATC_HOLD1_LSB     20
`define ATC_HOLD0_MSB     18
`define ATC_HOLD0_LSB     16
`define ATC_SLV_MSB       14
`define ATC_SLV_LSB       8
`define ATC_MST_MSB       6
`define ATC_MST_LSB       0

`define ATC_INT_STROBE    7'h0B
`define ATC_INT_RECOV     7'h09
`define ATC_INT_HOLD      3'h2

`endif

// ---- src/atc_pkg.sv ----
// atc_pkg: types shared by the ATA timing override block.
// assumes atc_params.svh supplies the numeric constants.
package atc_pkg;

   typedef enum logic [1:0] {
      ATC_IDLE   = 2'b00,
      ATC_STROBE = 2'b01,
      ATC_RECOV  = 2'b11
   } atc_state_t;

   typedef struct packed {
      logic write;
      logic slave;
      logic dataReg;
   } atc_req_t;

   typedef struct packed {
      logic [6:0] strobe;
      logic [6:0] recov;
      logic [2:0] hold;
   } atc_timing_t;

endpackage : atc_pkg

// ---- src/atc_timing.sv ----
// atc_timing: APB register file and strobe/recovery/hold sequencer
// of the ATA host port; one clock, requests come from same-clock logic.
//
// Function
// - two per-drive ultra-DMA enables, bit 1 drive 1, bit 0 drive 0
// - override bit 0 clear uses internal timing, set uses fields
// - programmable counts ignored unless the override bit is set
// - slave write data held N+1 cycles after strobe, N bits 22-20
// - master write data held N+1 cycles after strobe, N bits 18-16
// - slave task-file strobe lasts N+1 cycles, N bits 14-8
// - master task-file strobe lasts N+1 cycles, N bits 6-0
// - slave task-file recovery lasts N+1 cycles, N bits 14-8
// - master task-file recovery lasts N+1 cycles, N bits 6-0
// - slave data-register strobe lasts N+1 cycles, N bits 14-8
// - master data-register strobe lasts N+1 cycles, N bits 6-0
// - slave data-register recovery lasts N+1 cycles, N bits 14-8
// - master data-register recovery lasts N+1 cycles, N bits 6-0
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "atc_params.svh"

module atc_timing #(
   parameter int          DATA_W     = 16,
   parameter logic [6:0]  INT_STROBE = `ATC_INT_STROBE,
   parameter logic [6:0]  INT_RECOV  = `ATC_INT_RECOV,
   parameter logic [2:0]  INT_HOLD   = `ATC_INT_HOLD
) (
   input  wire logic                   core_clk,
   input  wire logic                   reset_n,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`ATC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   accReq,
   input  wire atc_pkg::atc_req_t      accCmd,
   input  wire logic [DATA_W-1:0]      accWrData,
   output logic                        accReady,
   output logic                        accDone,
   output logic                        readOeN,
   output logic                        writeOeN,
   output logic      [DATA_W-1:0]      ideDataOut,
   output logic                        ideDataOe,
   output logic                        drive1FastDmaOn,
   output logic                        drive0FastDmaOn,
   output logic                        timingOverride
);
   import atc_pkg::*;

   // register file
   logic [31:0]     ultraDmaDriveEnable;
   logic [31:0]     miscControl;
   logic [31:0]     taskfileStrobeWidth;
   logic [31:0]     taskfileRecoveryTime;
   logic [31:0]     pioDataStrobeWidth;
   logic [31:0]     pioDataRecoveryTime;

   // sequencer state
   atc_state_t      state;
   atc_state_t      next_state;
   logic [6:0]      cnt;
   logic [6:0]      next_cnt;
   logic [2:0]      holdCnt;
   logic [2:0]      next_holdCnt;
   logic            next_dataOe;
   logic            strobeOn;
   logic            next_strobeOn;
   logic            curWrite;
   logic            curSlave;
   logic            next_accReady;
   atc_timing_t     curTiming;
   atc_timing_t     pickTiming;
   logic            take;

   // bus decode
   logic            setupPhase;
   logic            apbWrite;
   logic [31:0]     rdValue;
   logic            addrHit;
   logic [31:0]     statusWord;

   // pick the slave or master 7-bit count of a timing register
   function automatic logic [6:0] fieldOf(
      input logic [31:0] r,
      input logic        slave
   );
      if (slave) begin
         fieldOf = r[`ATC_SLV_MSB:`ATC_SLV_LSB];
      end else begin
         fieldOf = r[`ATC_MST_MSB:`ATC_MST_LSB];
      end
   endfunction : fieldOf

   // write-data hold count for one drive
   function automatic logic [2:0] holdOf(
      input logic [31:0] r,
      input logic        slave
   );
      if (slave) begin
         holdOf = r[`ATC_HOLD1_MSB:`ATC_HOLD1_LSB];
      end else begin
         holdOf = r[`ATC_HOLD0_MSB:`ATC_HOLD0_LSB];
      end
   endfunction : holdOf

   // ------------------------------------------------------------------
   // timing selection for the request being offered
   // ------------------------------------------------------------------
   always_comb begin
      pickTiming.strobe = INT_STROBE;
      pickTiming.recov  = INT_RECOV;
      pickTiming.hold   = INT_HOLD;
      // counts only matter with the override set
      if (miscControl[`ATC_OVR_BIT]) begin
         pickTiming.hold = holdOf(miscControl, accCmd.slave);
         if (accCmd.dataReg) begin
            pickTiming.strobe = fieldOf(pioDataStrobeWidth, accCmd.slave);
            pickTiming.recov = fieldOf(pioDataRecoveryTime, accCmd.slave);
         end else begin
            pickTiming.strobe = fieldOf(taskfileStrobeWidth, accCmd.slave);
            pickTiming.recov = fieldOf(taskfileRecoveryTime, accCmd.slave);
         end
      end
   end

   assign take = accReq && accReady;

   // ------------------------------------------------------------------
   // sequencer next state
   // ------------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_holdCnt  = holdCnt;
      next_dataOe   = ideDataOe;
      next_strobeOn = strobeOn;

      // data stays driven N+1 cycles past the strobe's end
      if (ideDataOe && state == ATC_RECOV) begin
         if (holdCnt == 3'h0) begin
            next_dataOe = 1'b0;
         end else begin
            next_holdCnt = holdCnt - 3'h1;
         end
      end

      case (state)
         ATC_IDLE: begin
            next_state = ATC_IDLE;
         end
         ATC_STROBE: begin
            if (cnt == 7'h00) begin
               next_state    = ATC_RECOV;
               next_strobeOn = 1'b0;
               // limitation: recovery is that of the access just ended
               next_cnt      = curTiming.recov;
               next_holdCnt  = curTiming.hold;
            end else begin
               next_cnt = cnt - 7'h01;
            end
         end
         ATC_RECOV: begin
            if (cnt != 7'h00) begin
               next_cnt = cnt - 7'h01;
            end else if (!next_dataOe) begin
               next_state = ATC_IDLE;
            end
         end
         default: begin
            next_state    = ATC_IDLE;
            next_strobeOn = 1'b0;
            next_dataOe   = 1'b0;
         end
      endcase

      // a new access may start straight out of recovery
      if (take) begin
         next_state    = ATC_STROBE;
         next_cnt      = pickTiming.strobe;
         next_strobeOn = 1'b1;
         next_dataOe   = accCmd.write;
      end
   end

   // ready one cycle ahead so the gap is exactly one more than the larger of the recovery and write-hold counts
   always_comb begin
      next_accReady = (next_state == ATC_IDLE) ||
                      (next_state == ATC_RECOV && next_cnt == 7'h00 &&
                       (!next_dataOe || next_holdCnt == 3'h0));
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= ATC_IDLE;
         cnt       <= 7'h00;
         holdCnt   <= 3'h0;
         strobeOn  <= 1'b0;
         ideDataOe <= 1'b0;
         accReady  <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         holdCnt   <= next_holdCnt;
         strobeOn  <= next_strobeOn;
         ideDataOe <= next_dataOe;
         accReady  <= next_accReady;
      end
   end

   // snapshot of the access: later register writes cannot bend it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         curTiming  <= '0;
         curWrite   <= 1'b0;
         curSlave   <= 1'b0;
         ideDataOut <= '0;
      end else if (take) begin
         curTiming  <= pickTiming;
         curWrite   <= accCmd.write;
         curSlave   <= accCmd.slave;
         ideDataOut <= accWrData;
      end
   end

   // cable strobes, active low
   // registered so decode glitches never reach the cable
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         readOeN  <= 1'b1;
         writeOeN <= 1'b1;
         accDone  <= 1'b0;
      end else begin
         if (take) begin
            readOeN  <= accCmd.write;
            writeOeN <= !accCmd.write;
         end else begin
            readOeN  <= !(next_strobeOn && !curWrite);
            writeOeN <= !(next_strobeOn && curWrite);
         end
         accDone <= (state == ATC_STROBE) && (cnt == 7'h00);
      end
   end

   // ------------------------------------------------------------------
   // APB slave: data and answer prepared in the setup cycle
   // ------------------------------------------------------------------
   assign setupPhase = psel && !penable;
   assign apbWrite   = psel && penable && pready && pwrite && addrHit;

   assign statusWord = {27'h0, curSlave, ideDataOe, state, !accReady};

   always_comb begin
      rdValue = 32'h0000_0000;
      addrHit = 1'b1;
      case (paddr)
         `ATC_OFF_UDMA:   rdValue = ultraDmaDriveEnable;
         `ATC_OFF_MISC:   rdValue = miscControl;
         `ATC_OFF_TFSTB:  rdValue = taskfileStrobeWidth;
         `ATC_OFF_TFRCV:  rdValue = taskfileRecoveryTime;
         `ATC_OFF_PIOSTB: rdValue = pioDataStrobeWidth;
         `ATC_OFF_PIORCV: rdValue = pioDataRecoveryTime;
         `ATC_OFF_STATUS: rdValue = statusWord;
         default:         addrHit = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setupPhase) begin
         pready  <= 1'b1;
         pslverr <= !addrHit;
         prdata  <= pwrite ? 32'h0000_0000 : rdValue;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // reserved bits are masked so they always read zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ultraDmaDriveEnable  <= `ATC_REG_RESET;
         miscControl          <= `ATC_REG_RESET;
         taskfileStrobeWidth  <= `ATC_REG_RESET;
         taskfileRecoveryTime <= `ATC_REG_RESET;
         pioDataStrobeWidth   <= `ATC_REG_RESET;
         pioDataRecoveryTime  <= `ATC_REG_RESET;
      end else if (apbWrite) begin
         case (paddr)
            `ATC_OFF_UDMA: begin
               ultraDmaDriveEnable <= pwdata & `ATC_UDMA_MASK;
            end
            `ATC_OFF_MISC: begin
               miscControl <= pwdata & `ATC_MISC_MASK;
            end
            `ATC_OFF_TFSTB: begin
               taskfileStrobeWidth <= pwdata & `ATC_TIME_MASK;
            end
            `ATC_OFF_TFRCV: begin
               taskfileRecoveryTime <= pwdata & `ATC_TIME_MASK;
            end
            `ATC_OFF_PIOSTB: begin
               pioDataStrobeWidth <= pwdata & `ATC_TIME_MASK;
            end
            `ATC_OFF_PIORCV: begin
               pioDataRecoveryTime <= pwdata & `ATC_TIME_MASK;
            end
            default: begin
               ultraDmaDriveEnable <= ultraDmaDriveEnable;
            end
         endcase
      end
   end

   // mode bits handed to the DMA engines, registered copies
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive1FastDmaOn <= 1'b0;
         drive0FastDmaOn <= 1'b0;
         timingOverride  <= 1'b0;
      end else begin
         drive1FastDmaOn <= ultraDmaDriveEnable[1];
         drive0FastDmaOn <= ultraDmaDriveEnable[0];
         timingOverride  <= miscControl[`ATC_OVR_BIT];
      end
   end

endmodule : atc_timing

// ---- tb/ata_timing_override_config_tb_top.sv ----
// ata_timing_override_config_tb_top: register and cable timing bench.
// assumes atc_timing with its bound checker and atc_drive_model.
`timescale 1ns/100ps
`include "atc_params.svh"
module ata_timing_override_config_tb_top;
   import atc_pkg::*;
   logic        core_clk, reset_n, psel, penable, pwrite, accReq, err;
   logic        pready, pslverr, accReady, accDone, readOeN, writeOeN;
   logic        ideDataOe, drive1FastDmaOn, drive0FastDmaOn, timingOverride;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] accWrData, ideDataOut;
   atc_req_t    accCmd;
   int          lowLen, highLen, holdLen, bad_count, samples_checked;
   int          stbE [4] = '{1, 128, 10, 4};
   int          rcvE [4] = '{7, 10, 6, 9};
   logic [31:0] mask [6] = '{32'h3, 32'h770001, 32'h7F7F, 32'h7F7F,
                             32'h7F7F, 32'h7F7F};

   atc_timing i_atc_timing (
      .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .accReq, .accCmd, .accWrData, .accReady,
      .accDone, .readOeN, .writeOeN, .ideDataOut, .ideDataOe,
      .drive1FastDmaOn, .drive0FastDmaOn, .timingOverride);
   atc_drive_model i_atc_drive_model (
      .core_clk, .readOeN, .writeOeN, .ideDataOe, .lowLen, .highLen,
      .holdLen);

   always #10 core_clk = ~core_clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // 0 pready, 1 accReady, 2 accDone, 3 data released
   task automatic waitFor(input int k);
      int   n;
      logic s;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         s = k == 0 ? pready : k == 1 ? accReady
           : k == 2 ? accDone : !ideDataOe;
      end while (s !== 1'h1 && n < 300);
      if (s !== 1'h1) begin
         bad_count++;
         end_sim();
      end
   endtask : waitFor

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      waitFor(0);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask : apb

   // k bit 0 selects the slave, bit 1 the data register
   task automatic acc(input int k, input logic w);
      accReq <= 1'h1;
      accCmd <= '{w, k[0], k[1]};
      accWrData <= {12'hA5C, 4'(k)};
      waitFor(1);
      accReq <= 1'h0;
      waitFor(2);
      waitFor(3);
      @(posedge core_clk);
   endtask : acc

   initial begin
      {core_clk, reset_n, psel, penable, pwrite, accReq} = '0;
      {paddr, pwdata, accWrData, accCmd} = '0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'h1;
      @(posedge core_clk);
      for (int i = 0; i < 7; i++) begin
         apb(1'h0, 12'(4 * i), 32'h0);
         chk("reset value", q, 32'h0);
      end
      for (int i = 0; i < 6; i++) begin
         apb(1'h1, 12'(4 * i), 32'hFFFFFFFF);
         apb(1'h0, 12'(4 * i), 32'h0);
         chk("writable bits", q, mask[i]);
      end
      chk("override on", timingOverride, 1'h1);
      apb(1'h1, `ATC_OFF_UDMA, 32'h2);
      apb(1'h0, 12'h01C, 32'h0);
      chk("unmapped error", err, 1'h1);
      chk("fast dma bits", {drive1FastDmaOn, drive0FastDmaOn}, 2'h2);
      apb(1'h1, `ATC_OFF_UDMA, 32'h0);
      apb(1'h0, `ATC_OFF_UDMA, 32'h0);
      chk("fast dma off", {drive1FastDmaOn, drive0FastDmaOn}, 2'h0);
      $display("test registers done");
      apb(1'h1, `ATC_OFF_MISC, 32'h0);
      acc(0, 1'h1);
      chk("internal strobe", lowLen, `ATC_INT_STROBE + 1);
      chk("internal hold", holdLen, `ATC_INT_HOLD + 1);
      acc(0, 1'h0);
      chk("internal recovery", highLen, `ATC_INT_RECOV + 1);
      chk("override off", timingOverride, 1'h0);
      $display("test internal timing done");
      apb(1'h1, `ATC_OFF_MISC, 32'h410001);
      apb(1'h1, `ATC_OFF_TFSTB, 32'h7F00);
      apb(1'h1, `ATC_OFF_TFRCV, 32'h0906);
      apb(1'h1, `ATC_OFF_PIOSTB, 32'h0309);
      apb(1'h1, `ATC_OFF_PIORCV, 32'h0805);
      for (int k = 0; k < 4; k++) begin
         acc(k, 1'h1);
         chk("write strobe", lowLen, stbE[k]);
         chk("write hold", holdLen, k[0] ? 5 : 2);
         chk("write data", ideDataOut, {12'hA5C, 4'(k)});
         acc(k, 1'h0);
         chk("read strobe", lowLen, stbE[k]);
         chk("recovery", highLen, rcvE[k]);
      end
      $display("test override timing done");
      fork
         acc(1, 1'h0);
         begin
            repeat (5) @(posedge core_clk);
            apb(1'h1, `ATC_OFF_TFSTB, 32'h0);
            apb(1'h0, `ATC_OFF_STATUS, 32'h0);
            chk("busy status", q, 32'h13);
         end
      join
      chk("mid-access write", lowLen, 128);
      $display("test sampling done");
      reset_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'h1;
      @(posedge core_clk);
      apb(1'h0, `ATC_OFF_MISC, 32'h0);
      chk("misc after reset", q, 32'h0);
      chk("override after reset", timingOverride, 1'h0);
      $display("test mid-run reset done");
      end_sim();
   end
endmodule : ata_timing_override_config_tb_top

// ---- tb/atc_drive_model.sv ----
// atc_drive_model: drive-side observer of the cable strobes.
// assumes active-low strobes and a host data enable, one clock.
`timescale 1ns/100ps
module atc_drive_model (
   input  wire logic core_clk,
   input  wire logic readOeN,
   input  wire logic writeOeN,
   input  wire logic ideDataOe,
   output int        lowLen,
   output int        highLen,
   output int        holdLen
);
   int lo, hi, hd;
   // a drive only sees levels; lengths counted in host cycles
   always_ff @(posedge core_clk) begin
      if (readOeN && writeOeN) begin
         lo <= 0;
         hi <= hi + 1;
         if (lo != 0) lowLen <= lo;
      end else begin
         lo <= lo + 1;
         hi <= 0;
         if (hi != 0) highLen <= hi;
      end
   end
   always_ff @(posedge core_clk) begin
      hd <= (ideDataOe && readOeN && writeOeN) ? hd + 1 : 0;
      if (!ideDataOe && hd != 0) holdLen <= hd;
   end
endmodule : atc_drive_model

// ---- tb/atc_timing_properties.sv ----
// atc_timing_properties: port-level checks of the timing sequencer.
// assumes one clock and the offsets of atc_params.svh.
`timescale 1ns/100ps
`include "atc_params.svh"
module atc_timing_properties #(
   parameter logic [6:0] INT_STROBE = `ATC_INT_STROBE,
   parameter logic [6:0] INT_RECOV  = `ATC_INT_RECOV,
   parameter logic [2:0] INT_HOLD   = `ATC_INT_HOLD
) (
   input wire logic              core_clk,
   input wire logic              reset_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              accReq,
   input wire atc_pkg::atc_req_t accCmd,
   input wire logic              accReady,
   input wire logic              accDone,
   input wire logic              readOeN,
   input wire logic              writeOeN,
   input wire logic              ideDataOe,
   input wire logic              drive1FastDmaOn,
   input wire logic              drive0FastDmaOn,
   input wire logic              timingOverride
);
   import atc_pkg::*;
   logic        wr, take, strbN;
   logic [31:0] tfS, tfR, pdS, pdR, misc;
   logic [6:0]  curS, curR, rcvR;
   logic [2:0]  curH, holdH;
   logic [7:0]  lowCnt, hiCnt, hdCnt;

   function automatic logic [6:0] fld(logic [31:0] r, logic s);
      return s ? r[14:8] : r[6:0];
   endfunction : fld

   assign wr    = psel && penable && pready && pwrite;
   assign take  = accReq && accReady;
   assign strbN = readOeN && writeOeN;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {tfS, tfR, pdS, pdR, misc} <= '0;
      end else if (wr) begin
         case (paddr)
            `ATC_OFF_MISC:   misc <= pwdata;
            `ATC_OFF_TFSTB:  tfS <= pwdata;
            `ATC_OFF_TFRCV:  tfR <= pwdata;
            `ATC_OFF_PIOSTB: pdS <= pwdata;
            `ATC_OFF_PIORCV: pdR <= pwdata;
            default: ;
         endcase
      end
   end

   // figures fixed at take, so later writes cannot reach them
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {curS, curR, curH} <= '0;
      end else if (take) begin
         curS <= misc[0] ? fld(accCmd.dataReg ? pdS : tfS, accCmd.slave)
                         : INT_STROBE;
         curR <= misc[0] ? fld(accCmd.dataReg ? pdR : tfR, accCmd.slave)
                         : INT_RECOV;
         curH <= !misc[0] ? INT_HOLD
                          : accCmd.slave ? misc[22:20] : misc[18:16];
      end
   end

   // high count saturates so long idle gaps never wrap
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {lowCnt, hiCnt, hdCnt, rcvR, holdH} <= '0;
      end else begin
         lowCnt <= strbN ? 8'h00 : lowCnt + 8'h01;
         hiCnt <= !strbN ? 8'h00 : hiCnt + {7'h00, hiCnt != 8'hFF};
         hdCnt <= (strbN && ideDataOe) ? hdCnt + 8'h01 : 8'h00;
         if (strbN && lowCnt != 8'h00) begin
            rcvR <= curR;
            holdH <= curH;
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence internalTake;
      take && !misc[0];
   endsequence
   // twelve low cycles: default internal strobe count only
   sequence internalStrobe;
      (!strbN) [*8] ##1 (!strbN) [*4] ##1 strbN;
   endsequence

   udma_copy_a: assert property (wr && paddr == `ATC_OFF_UDMA |->
      ##2 drive1FastDmaOn == $past(pwdata[1], 2)
      && drive0FastDmaOn == $past(pwdata[0], 2))
      else $error("fast DMA enables not copied");
   override_copy_a: assert property (wr && paddr == `ATC_OFF_MISC |->
      ##2 timingOverride == $past(pwdata[0], 2))
      else $error("override select not copied");
   internal_strobe_a: assert property (internalTake |=> internalStrobe)
      else $error("internal strobe width wrong");
   strobe_width_a: assert property (
      $rose(strbN) |-> lowCnt == {1'b0, curS} + 8'h01)
      else $error("strobe width wrong");
   recovery_min_a: assert property (
      $fell(strbN) |-> hiCnt >= {1'b0, rcvR} + 8'h01)
      else $error("recovery too short");
   write_hold_a: assert property (
      $fell(ideDataOe) |-> hdCnt == {5'h00, holdH} + 8'h01)
      else $error("write hold wrong");
   done_pulse_a: assert property (accDone == $rose(strbN))
      else $error("done pulse misplaced");
   write_start_a: assert property (take && accCmd.write |=>
      !writeOeN && readOeN && ideDataOe && !accReady)
      else $error("write strobe start wrong");
   read_start_a: assert property (take && !accCmd.write |=>
      !readOeN && writeOeN && !ideDataOe)
      else $error("read strobe start wrong");
endmodule : atc_timing_properties

bind atc_timing atc_timing_properties #(.INT_STROBE(INT_STROBE),
   .INT_RECOV(INT_RECOV), .INT_HOLD(INT_HOLD)) i_atc_timing_properties (
   .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .accReq, .accCmd, .accReady, .accDone, .readOeN, .writeOeN,
   .ideDataOe, .drive1FastDmaOn, .drive0FastDmaOn, .timingOverride);
